// >>> src/pmf_pkg.sv
// Summary of operation
// - Read mode returns one byte per address
// - Auto-program takes whole 128-byte units
// - Auto-erase clears whole array, then polled
// - Data line 6 shows normal termination
// - Status read drives error information
// - Command write: gate high, strobe low
// - Select high: float, ignore controls, keep running
// - Ignore commands during settle and setup waits
// - Enter read mode after setup without command
// - Write guard blocks programming and erasing
package pmf_pkg;
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned OSC_SETTLE_WAIT_MS = 30;
    localparam int unsigned PROM_SETUP_MS = 10;
    localparam int unsigned OSC_SETTLE_CYC = OSC_SETTLE_WAIT_MS * (CLK_HZ / 1000);
    localparam int unsigned PROM_SETUP_CYC = PROM_SETUP_MS * (CLK_HZ / 1000);
    localparam int unsigned TMR_W = 24;
    localparam int unsigned ADDR_W_DEF = 19;
    localparam int unsigned UNIT_BYTES = 128;
    localparam int unsigned UNIT_W = 7;
    // Command codes
    localparam logic [7:0] CMD_READ = 8'h00;
    localparam logic [7:0] CMD_ERASE = 8'h20;
    localparam logic [7:0] CMD_PROG = 8'h40;
    localparam logic [7:0] CMD_STATUS = 8'h71;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    // Status byte layout
    localparam int unsigned STAT_DONE_BIT = 7;
    localparam int unsigned STAT_OK_BIT = 6;
    localparam int unsigned STAT_ERASE_ERR_BIT = 5;
    localparam int unsigned STAT_PROG_ERR_BIT = 4;
    localparam logic [7:0] STAT_RESET = 8'h00;
    // Pin levels that select the programming configuration
    localparam logic [2:0] PROM_MODE_SEL = 3'h7;
    localparam logic [2:0] PROM_CFG_SEL = 3'h0;
    typedef enum logic [2:0] {
        ST_WAIT_OSC = 3'h0,
        ST_WAIT_SETUP = 3'h1,
        ST_READ = 3'h3,
        ST_PROG_LOAD = 3'h2,
        ST_PROG_BUSY = 3'h6,
        ST_STATUS = 3'h7,
        ST_ERASE_BUSY = 3'h5
    } pmf_state_t;
endpackage

// >>> src/pmf_sync.sv
`timescale 1ns/1ps
// Three-stage pin synchroniser; a bit is taken once stages two and three agree
module pmf_sync #(
    parameter int unsigned W = 8,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] filt_out
);
    logic [W-1:0] s1_q, s2_q, s3_q, filt_d;

    ////////////////////////////////////////////////////////////////
    // Per-bit agreement filter
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_comb begin
            filt_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : filt_out[i];
        end
    end

    // First stage feeds only the second, to keep metastability contained
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
            filt_out <= RST_VAL;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            filt_out <= filt_d;
        end
    end
endmodule

// >>> src/pmf_port.sv
`timescale 1ns/1ps
// Parallel programming port of the on-chip flash
module pmf_port
    import pmf_pkg::*;
#(
    parameter int unsigned ADDR_W = ADDR_W_DEF,
    parameter int unsigned OSC_CYC = OSC_SETTLE_CYC,
    parameter int unsigned SETUP_CYC = PROM_SETUP_CYC
) (
    input wire logic CLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic CHIP_SEL_N_IN,
    input wire logic OUT_GATE_N_IN,
    input wire logic WR_STROBE_N_IN,
    input wire logic FLASH_WRITE_GUARD_IN,
    input wire logic MODE_SELECT_2_IN,
    input wire logic MODE_SELECT_1_IN,
    input wire logic MODE_SELECT_0_IN,
    input wire logic PROM_CONFIG_PIN_A_IN,
    input wire logic PROM_CONFIG_PIN_B_IN,
    input wire logic PROM_CONFIG_PIN_C_IN,
    input wire logic [ADDR_W-1:0] ADDR_IN,
    input wire logic [7:0] DATA_IN,
    output logic [7:0] DATA_OUT,
    output logic DATA_OE_N_OUT
);
    localparam int unsigned NIN = ADDR_W + 18;
    localparam int unsigned DEPTH = 1 << ADDR_W;
    localparam logic [ADDR_W-1:0] UNIT_LAST = ADDR_W'(UNIT_BYTES - 1);
    localparam logic [ADDR_W-1:0] MEM_LAST = '1;
    localparam logic [TMR_W-1:0] OSC_LOAD = TMR_W'(OSC_CYC - 1);
    localparam logic [TMR_W-1:0] SETUP_LOAD = TMR_W'(SETUP_CYC - 1);

    // Refuse sizes that the unit split or the wait counters cannot serve
    if (ADDR_W <= UNIT_W || OSC_CYC < 1 || SETUP_CYC < 1 ||
        OSC_CYC >= (1 << TMR_W) || SETUP_CYC >= (1 << TMR_W)) begin : g_bad_param
        $error("pmf_port: unsupported parameter values");
    end

    ////////////////////////////////////////////////////////////////
    // Pin conditioning
    logic [NIN-1:0] filt;
    logic ce_n_f, oe_n_f, we_n_f, guard_f;
    logic [2:0] mode_f, cfg_f;
    logic [ADDR_W-1:0] addr_f;
    logic [7:0] din_f;

    pmf_sync #(
        .W(NIN),
        .RST_VAL({3'h7, (NIN - 3)'(0)})
    ) u_sync (
        .clk_in(CLK_IN),
        .rst_in(SYS_RST_IN),
        .pin_in({CHIP_SEL_N_IN, OUT_GATE_N_IN, WR_STROBE_N_IN, FLASH_WRITE_GUARD_IN,
                 MODE_SELECT_2_IN, MODE_SELECT_1_IN, MODE_SELECT_0_IN,
                 PROM_CONFIG_PIN_A_IN, PROM_CONFIG_PIN_B_IN, PROM_CONFIG_PIN_C_IN,
                 ADDR_IN, DATA_IN}),
        .filt_out(filt)
    );

    assign ce_n_f = filt[NIN-1];
    assign oe_n_f = filt[NIN-2];
    assign we_n_f = filt[NIN-3];
    assign guard_f = filt[NIN-4];
    assign mode_f = filt[NIN-5 -: 3];
    assign cfg_f = filt[NIN-8 -: 3];
    assign addr_f = filt[ADDR_W+7:8];
    assign din_f = filt[7:0];

    ////////////////////////////////////////////////////////////////
    // Command capture on the strobe's rising edge while selected
    pmf_state_t state_q, state_d;
    logic we_n_prev_q;
    logic wr_rise, prom_sel, cmd_ok, waiting;

    assign wr_rise = !we_n_prev_q && we_n_f && !ce_n_f && oe_n_f;
    assign prom_sel = (mode_f == PROM_MODE_SEL) && (cfg_f == PROM_CFG_SEL);
    assign waiting = (state_q == ST_WAIT_OSC) || (state_q == ST_WAIT_SETUP);
    assign cmd_ok = wr_rise && prom_sel && !waiting;

    ////////////////////////////////////////////////////////////////
    // Storage: flash array and the program unit buffer
    logic [7:0] mem [DEPTH];
    logic [7:0] unit_buf [UNIT_BYTES];
    logic mem_we, buf_we;
    logic [ADDR_W-1:0] mem_wa;
    logic [7:0] mem_wd, rd_byte;

    assign rd_byte = mem[addr_f];

    // No reset on the arrays: flash content survives a reset
    always_ff @(posedge CLK_IN) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
        if (buf_we) begin
            unit_buf[addr_f[UNIT_W-1:0]] <= din_f;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Mode sequencer
    logic [TMR_W-1:0] tmr_q, tmr_d;
    logic [ADDR_W-1:0] cnt_q, cnt_d;
    logic [ADDR_W-UNIT_W-1:0] page_q, page_d;
    logic [7:0] stat_q, stat_d;

    always_comb begin
        state_d = state_q;
        tmr_d = tmr_q;
        cnt_d = cnt_q;
        page_d = page_q;
        stat_d = stat_q;
        mem_we = 1'b0;
        mem_wa = cnt_q;
        mem_wd = ERASED_BYTE;
        buf_we = 1'b0;
        case (state_q)
            ST_WAIT_OSC: begin
                if (tmr_q == '0) begin
                    state_d = ST_WAIT_SETUP;
                    tmr_d = SETUP_LOAD;
                end else begin
                    tmr_d = tmr_q - 1'b1;
                end
            end
            ST_WAIT_SETUP: begin
                if (tmr_q == '0) begin
                    state_d = ST_READ;
                end else begin
                    tmr_d = tmr_q - 1'b1;
                end
            end
            ST_READ, ST_STATUS: begin
                if (cmd_ok) begin
                    case (din_f)
                        CMD_PROG: begin
                            state_d = ST_PROG_LOAD;
                            cnt_d = '0;
                        end
                        CMD_ERASE: begin
                            state_d = ST_ERASE_BUSY;
                            cnt_d = '0;
                            stat_d = STAT_RESET;
                        end
                        CMD_STATUS: state_d = ST_STATUS;
                        CMD_READ: state_d = ST_READ;
                        default: state_d = state_q;
                    endcase
                end
            end
            ST_PROG_LOAD: begin
                if (cmd_ok) begin
                    buf_we = 1'b1;
                    if (cnt_q == '0) begin
                        page_d = addr_f[ADDR_W-1:UNIT_W];
                    end
                    if (cnt_q == UNIT_LAST) begin
                        state_d = ST_PROG_BUSY;
                        cnt_d = '0;
                        stat_d = STAT_RESET;
                    end else begin
                        cnt_d = cnt_q + 1'b1;
                    end
                end
            end
            ST_PROG_BUSY: begin
                mem_we = guard_f;
                mem_wa = {page_q, cnt_q[UNIT_W-1:0]};
                mem_wd = unit_buf[cnt_q[UNIT_W-1:0]];
                stat_d[STAT_PROG_ERR_BIT] = stat_q[STAT_PROG_ERR_BIT] | !guard_f;
                if (cnt_q == UNIT_LAST) begin
                    state_d = ST_STATUS;
                    stat_d[STAT_DONE_BIT] = 1'b1;
                    stat_d[STAT_OK_BIT] = !stat_q[STAT_PROG_ERR_BIT] && guard_f;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            ST_ERASE_BUSY: begin
                mem_we = guard_f;
                stat_d[STAT_ERASE_ERR_BIT] = stat_q[STAT_ERASE_ERR_BIT] | !guard_f;
                if (cnt_q == MEM_LAST) begin
                    state_d = ST_STATUS;
                    stat_d[STAT_DONE_BIT] = 1'b1;
                    stat_d[STAT_OK_BIT] = !stat_q[STAT_ERASE_ERR_BIT] && guard_f;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            default: state_d = ST_WAIT_OSC;
        endcase
    end

    // Reset stands for standby release, so the settle wait restarts with it
    always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            state_q <= ST_WAIT_OSC;
            tmr_q <= OSC_LOAD;
            cnt_q <= '0;
            page_q <= '0;
            stat_q <= STAT_RESET;
            we_n_prev_q <= 1'b1;
        end else begin
            state_q <= state_d;
            tmr_q <= tmr_d;
            cnt_q <= cnt_d;
            page_q <= page_d;
            stat_q <= stat_d;
            we_n_prev_q <= we_n_f;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Data pins: array byte in read mode, status byte in every other mode, floated during the settle and setup waits
    logic [7:0] dout_d;
    logic oe_n_d, drive;

    always_comb begin
        drive = !ce_n_f && !oe_n_f && we_n_f && !waiting;
        oe_n_d = !drive;
        dout_d = (state_q == ST_READ) ? rd_byte : stat_q;
    end

    // Registered so the pins never glitch while the filter settles
    always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            DATA_OUT <= 8'h00;
            DATA_OE_N_OUT <= 1'b1;
        end else begin
            DATA_OUT <= dout_d;
            DATA_OE_N_OUT <= oe_n_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (SYS_RST_IN);

    sequence s_unit_full;
        state_q == ST_PROG_LOAD && cmd_ok && cnt_q == UNIT_LAST;
    endsequence
    sequence s_prog_run;
        (state_q == ST_PROG_BUSY) [*8] ##121 (state_q == ST_STATUS);
    endsequence

    property p_read_byte;
        state_q == ST_READ && !mem_we |=> DATA_OUT === $past(rd_byte);
    endproperty
    a_read_byte: assert property (p_read_byte) else $error("read byte mismatch");

    property p_unit_prog;
        s_unit_full |=> s_prog_run;
    endproperty
    a_unit_prog: assert property (p_unit_prog) else $error("unit program sequence");

    property p_erase_walk;
        state_q == ST_ERASE_BUSY && cnt_q != MEM_LAST |=>
            state_q == ST_ERASE_BUSY && cnt_q == $past(cnt_q) + 1'b1;
    endproperty
    a_erase_walk: assert property (p_erase_walk) else $error("erase walk stalled");

    property p_status_out;
        state_q != ST_READ |=> DATA_OUT == $past(stat_q);
    endproperty
    a_status_out: assert property (p_status_out) else $error("status byte wrong");

    property p_read_drive;
        !ce_n_f && !oe_n_f && we_n_f && state_q == ST_READ |=> !DATA_OE_N_OUT;
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("read not driven");

    property p_float;
        ce_n_f || (oe_n_f && we_n_f) |=> DATA_OE_N_OUT;
    endproperty
    a_float: assert property (p_float) else $error("pins driven while idle");

    property p_wait_ignore;
        waiting && wr_rise |=> state_q == ST_WAIT_OSC || state_q == ST_WAIT_SETUP ||
            state_q == ST_READ;
    endproperty
    a_wait_ignore: assert property (p_wait_ignore) else $error("command during wait");

    property p_auto_read;
        state_q == ST_WAIT_SETUP && tmr_q == '0 |=> state_q == ST_READ;
    endproperty
    a_auto_read: assert property (p_auto_read) else $error("no read mode after setup");

    property p_guard;
        !guard_f |-> !mem_we;
    endproperty
    a_guard: assert property (p_guard) else $error("write without guard");

    property p_cmd_latch;
        state_q == ST_READ && cmd_ok && din_f == CMD_ERASE |=> state_q == ST_ERASE_BUSY;
    endproperty
    a_cmd_latch: assert property (p_cmd_latch) else $error("command not taken");
endmodule

// >>> tb/pmf_prog_model.sv
`timescale 1ns/1ps
// Behavioural programmer that owns every pin on the far side of the port except clock and reset
module pmf_prog_model
    import pmf_pkg::*;
#(
    parameter int unsigned AW = 10
) (
    input wire logic clk_in,
    input wire logic [7:0] data_out_in,
    input wire logic data_oe_n_in,
    output logic ce_n_out,
    output logic oe_n_out,
    output logic we_n_out,
    output logic guard_out,
    output logic [2:0] mode_out,
    output logic [2:0] cfg_out,
    output logic [AW-1:0] addr_out,
    output logic [7:0] bus_out
);
    logic drv_q;
    logic [7:0] dq_q;
    ////////////////////////////////////////
    // Wire level; once both sides let go it shows the inverse of the last byte, not a stale copy
    assign bus_out = !data_oe_n_in ? data_out_in : (drv_q ? dq_q : ~dq_q);
    // Idle pins, with the programming configuration strapped
    initial begin
        drv_q = 1'b0;
        dq_q = 8'h00;
        ce_n_out = 1'b1;
        oe_n_out = 1'b1;
        we_n_out = 1'b1;
        guard_out = 1'b1;
        addr_out = '0;
        mode_out = PROM_MODE_SEL;
        cfg_out = PROM_CFG_SEL;
    end
    ////////////////////////////////////////
    // Pins only move just after a falling edge
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    // Command write; data and address stay put well around the strobe rise
    task automatic wr(input logic [7:0] d, input logic [AW-1:0] a);
        addr_out = a;
        dq_q = d;
        drv_q = 1'b1;
        ce_n_out = 1'b0;
        oe_n_out = 1'b1;
        cyc(2);
        we_n_out = 1'b0;
        cyc(6);
        we_n_out = 1'b1;
        cyc(6);
        drv_q = 1'b0;
        cyc(1);
    endtask
    // Byte read; address held long enough for the pin filter
    task automatic rd(input logic [AW-1:0] a, output logic [7:0] d, output logic oe_n);
        addr_out = a;
        ce_n_out = 1'b0;
        we_n_out = 1'b1;
        oe_n_out = 1'b0;
        cyc(7);
        d = bus_out;
        oe_n = data_oe_n_in;
        oe_n_out = 1'b1;
        cyc(6);
    endtask
    // Completion is polled for up to 200 reads rather than timed, so a slow device is still judged fairly
    task automatic poll(output logic [7:0] st);
        logic oe;
        st = 8'h00;
        for (int i = 0; i < 200 && st[STAT_DONE_BIT] !== 1'b1; i++) begin
            rd('0, st, oe);
        end
    endtask
endmodule

// >>> tb/tb_prom_mode_flash_port.sv
`timescale 1ns/1ps
// Self-checking bench for the flash programming port
module tb_prom_mode_flash_port
    import pmf_pkg::*;
;
    localparam int unsigned AW = 10;
    localparam logic [7:0] ST_OK = 8'h01 << STAT_DONE_BIT | 8'h01 << STAT_OK_BIT;
    logic clk, rst, ce_n, oe_n, we_n, guard, data_oe_n;
    logic [2:0] mode, cfg;
    logic [AW-1:0] addr;
    logic [7:0] bus, data_out;
    int n_mismatch = 0;
    int total_checks = 0;
    int cyc_cnt = 0;
    ////////////////////////////////////////
    pmf_port #(.ADDR_W(AW), .OSC_CYC(20), .SETUP_CYC(10)) dut (
        .CLK_IN(clk), .SYS_RST_IN(rst), .CHIP_SEL_N_IN(ce_n), .OUT_GATE_N_IN(oe_n),
        .WR_STROBE_N_IN(we_n), .FLASH_WRITE_GUARD_IN(guard),
        .MODE_SELECT_2_IN(mode[2]), .MODE_SELECT_1_IN(mode[1]), .MODE_SELECT_0_IN(mode[0]),
        .PROM_CONFIG_PIN_A_IN(cfg[0]), .PROM_CONFIG_PIN_B_IN(cfg[1]),
        .PROM_CONFIG_PIN_C_IN(cfg[2]), .ADDR_IN(addr), .DATA_IN(bus),
        .DATA_OUT(data_out), .DATA_OE_N_OUT(data_oe_n));
    pmf_prog_model #(.AW(AW)) pm (
        .clk_in(clk), .data_out_in(data_out), .data_oe_n_in(data_oe_n), .ce_n_out(ce_n),
        .oe_n_out(oe_n), .we_n_out(we_n), .guard_out(guard), .mode_out(mode),
        .cfg_out(cfg), .addr_out(addr), .bus_out(bus));
    ////////////////////////////////////////
    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Hang guard; the whole run needs well under this many cycles
    always @(posedge clk) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            n_mismatch++;
            summarize();
        end
    end
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////
    // A command and a read during the settle and setup waits are both ignored
    task automatic t_wait();
        logic [7:0] d;
        logic oe;
        pm.wr(CMD_ERASE, '0);
        pm.rd('0, d, oe);
        chk("wait float", 8'h01, {7'h0, oe});
        pm.cyc(30);
    endtask
    // Read mode with no command, then the two floating pin settings
    task automatic t_float();
        logic [7:0] d;
        logic oe;
        pm.rd('0, d, oe);
        chk("read drive", 8'h00, {7'h0, oe});
        pm.cyc(8);
        chk("gate high float", 8'h01, {7'h0, data_oe_n});
        pm.ce_n_out = 1'b1;
        pm.oe_n_out = 1'b0;
        pm.cyc(8);
        chk("select high float", 8'h01, {7'h0, data_oe_n});
        pm.oe_n_out = 1'b1;
    endtask
    // Whole-array erase, polled, blank reads, then config guard and status read
    task automatic t_erase();
        logic [7:0] d;
        logic oe;
        pm.wr(CMD_ERASE, '0);
        pm.poll(d);
        chk("erase status", ST_OK, d);
        pm.wr(CMD_READ, '0);
        pm.rd('0, d, oe);
        chk("erased low", ERASED_BYTE, d);
        pm.rd('1, d, oe);
        chk("erased high", ERASED_BYTE, d);
        pm.cfg_out = 3'h1;
        pm.wr(CMD_STATUS, '0);
        pm.cfg_out = PROM_CFG_SEL;
        pm.rd('0, d, oe);
        chk("wrong config ignored", ERASED_BYTE, d);
        pm.wr(CMD_STATUS, '0);
        pm.rd('1, d, oe);
        chk("status read", ST_OK, d);
    endtask
    // One 128-byte unit, written then read back byte by byte
    task automatic t_prog();
        logic [7:0] d;
        logic oe;
        pm.wr(CMD_PROG, '0);
        for (int i = 0; i < UNIT_BYTES; i++) pm.wr(8'(i) ^ 8'h5a, AW'(128 + i));
        pm.poll(d);
        chk("prog status", ST_OK, d);
        pm.wr(CMD_READ, '0);
        for (int i = 0; i < UNIT_BYTES; i++) begin
            pm.rd(AW'(128 + i), d, oe);
            chk("prog byte", 8'(i) ^ 8'h5a, d);
        end
        pm.rd(AW'(256), d, oe);
        chk("next unit blank", ERASED_BYTE, d);
    endtask
    // Guard low blocks both a unit program and an erase, with error status
    task automatic t_guard();
        logic [7:0] d;
        logic oe;
        pm.guard_out = 1'b0;
        pm.wr(CMD_PROG, '0);
        for (int i = 0; i < UNIT_BYTES; i++) pm.wr(8'h00, AW'(256 + i));
        pm.poll(d);
        chk("guard prog status", 8'h01 << STAT_DONE_BIT | 8'h01 << STAT_PROG_ERR_BIT, d);
        pm.wr(CMD_ERASE, '0);
        pm.poll(d);
        chk("guard erase status", 8'h01 << STAT_DONE_BIT | 8'h01 << STAT_ERASE_ERR_BIT, d);
        pm.guard_out = 1'b1;
        pm.wr(CMD_READ, '0);
        pm.rd(AW'(256), d, oe);
        chk("guarded unit", ERASED_BYTE, d);
        pm.rd(AW'(128), d, oe);
        chk("kept byte", 8'h5a, d);
    endtask
    ////////////////////////////////////////
    // Reset as standby release, then the scenarios in order
    initial begin
        rst = 1'b1;
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        t_wait();
        t_float();
        t_erase();
        t_prog();
        t_guard();
        summarize();
    end
endmodule
